// >>> hdl/net_cfg_pkg.sv
`default_nettype none

package net_cfg_pkg;

	// ****************************************************************
	// Bus and register indices
	// ****************************************************************
	localparam int          ADDR_W     = 32;
	localparam int          DATA_W     = 32;
	localparam int          IDX_W      = 24;
	localparam int          IDX_LSB    = 2;
	localparam logic [23:0] IDX_MODE   = 24'hFE_0000;
	localparam logic [23:0] IDX_GW     = 24'hFE_0001;
	localparam logic [23:0] IDX_MASK   = 24'hFE_0005;
	localparam logic [23:0] IDX_HW     = 24'hFE_0009;
	localparam logic [23:0] IDX_IP     = 24'hFE_000F;
	localparam logic [23:0] IDX_LAST   = 24'hFE_0012;

	// ****************************************************************
	// Mode control field layout and reset values
	// ****************************************************************
	localparam int         MODE_RST_BIT   = 7;
	localparam int         MODE_ECHO_BIT  = 4;
	localparam int         MODE_PPPOE_BIT = 3;
	localparam logic [7:0] MODE_RESET     = 8'h00;
	localparam logic [7:0] OCTET_RESET    = 8'h00;
	localparam int         OCTET_W        = 8;
	localparam int         NUM_OCTETS     = 18;
	localparam int         SLOT_W         = 5;
	localparam int         INIT_CYCLES    = 4;
	localparam int         INIT_CNT_W     = 8;

	// ****************************************************************
	// Carriers
	// ****************************************************************
	typedef struct packed {
		logic [31:0] paddr;
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [31:0] pwdata;
	} apb_req_s;

	typedef struct packed {
		logic [31:0] prdata;
		logic        pready;
		logic        pslverr;
	} apb_rsp_s;

	typedef struct packed {
		logic        echoReplyBlock;
		logic        pppoeEnable;
		logic [31:0] gatewayAddress;
		logic [31:0] subnetMask;
		logic [47:0] localHwAddress;
		logic [31:0] localIpAddress;
	} net_cfg_s;

	typedef enum logic [0:0] {
		ST_RUN  = 1'b0,
		ST_INIT = 1'b1
	} init_state_e;

endpackage

`default_nettype wire

// >>> hdl/net_common_config_regs.sv
`timescale 1ns/100ps
`default_nettype none

module net_common_config_regs #(
	parameter int INIT_LEN = net_cfg_pkg::INIT_CYCLES
) (
	// Clock and reset
	input  wire logic                 sys_clk,
	input  wire logic                 rstn,
	// Register bus
	input  wire net_cfg_pkg::apb_req_s apbReq,
	output var  net_cfg_pkg::apb_rsp_s apbRsp,
	// Configuration to the protocol engine
	output wire net_cfg_pkg::net_cfg_s cfg,
	output var  logic                 initBusy
);
	import net_cfg_pkg::*;

	// ****************************************************************
	// Elaboration check
	// ****************************************************************
	if (INIT_LEN < 1 || INIT_LEN > (2 ** INIT_CNT_W) - 1) begin : g_bad_len
		$error("INIT_LEN out of range");
	end

	if (NUM_OCTETS != int'(IDX_LAST - IDX_GW) + 1) begin : g_bad_map
		$error("octet store does not match the register map");
	end

	// ****************************************************************
	// Decode helpers
	// ****************************************************************
	function automatic logic [IDX_W-1:0] regIndex(input logic [ADDR_W-1:0] a);
		regIndex = a[IDX_LSB +: IDX_W];
	endfunction

	function automatic logic isMapped(input logic [ADDR_W-1:0] a);
		logic [IDX_W-1:0] i;
		i = regIndex(a);
		isMapped = (a[IDX_LSB-1:0] == '0) && (a[ADDR_W-1:IDX_LSB+IDX_W] == '0)
			&& (i >= IDX_MODE) && (i <= IDX_LAST);
	endfunction

	function automatic logic [SLOT_W-1:0] octetSlot(input logic [IDX_W-1:0] i);
		logic [IDX_W-1:0] d;
		d = i - IDX_GW;
		octetSlot = d[SLOT_W-1:0];
	endfunction

	// ****************************************************************
	// State
	// ****************************************************************
	init_state_e          state_r;
	logic [INIT_CNT_W-1:0] initCount_r;
	logic                 echoBlock_r;
	logic                 pppoe_r;
	logic [OCTET_W-1:0]   octet_r [NUM_OCTETS];

	logic             accessPend;
	logic             accessDone;
	logic             wrDone;
	logic [IDX_W-1:0] reqIdx;
	logic             reqMapped;
	logic             softReq;
	logic             octetWr;
	logic [OCTET_W-1:0] modeRead;

	assign reqIdx     = regIndex(apbReq.paddr);
	assign reqMapped  = isMapped(apbReq.paddr);
	assign accessPend = apbReq.psel && apbReq.penable && !apbRsp.pready && state_r == ST_RUN;
	assign accessDone = apbReq.psel && apbReq.penable && apbRsp.pready;
	assign wrDone     = accessDone && apbReq.pwrite && reqMapped;
	assign softReq    = wrDone && reqIdx == IDX_MODE && apbReq.pwdata[MODE_RST_BIT];
	assign octetWr    = wrDone && reqIdx != IDX_MODE && state_r == ST_RUN;

	always_comb begin
		modeRead                 = MODE_RESET;
		modeRead[MODE_RST_BIT]   = state_r == ST_INIT;
		modeRead[MODE_ECHO_BIT]  = echoBlock_r;
		modeRead[MODE_PPPOE_BIT] = pppoe_r;
	end

	// ****************************************************************
	// Soft reinitialisation sequencer
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			state_r     <= ST_RUN;
			initCount_r <= '0;
		end else begin
			case (state_r)
				ST_RUN: begin
					if (softReq) begin
						state_r     <= ST_INIT;
						initCount_r <= INIT_CNT_W'(INIT_LEN - 1);
					end
				end
				ST_INIT: begin
					if (initCount_r == '0) begin
						state_r <= ST_RUN;
					end else begin
						initCount_r <= initCount_r - 1'b1;
					end
				end
				default: begin
					state_r <= ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			initBusy <= 1'b0;
		end else begin
			initBusy <= (state_r == ST_RUN) ? softReq : (initCount_r != '0);
		end
	end

	// ****************************************************************
	// Mode control bits
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (!rstn || state_r == ST_INIT || softReq) begin
			echoBlock_r <= MODE_RESET[MODE_ECHO_BIT];
			pppoe_r     <= MODE_RESET[MODE_PPPOE_BIT];
		end else if (wrDone && reqIdx == IDX_MODE) begin
			echoBlock_r <= apbReq.pwdata[MODE_ECHO_BIT];
			pppoe_r     <= apbReq.pwdata[MODE_PPPOE_BIT];
		end
	end

	// ****************************************************************
	// Address octets
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (!rstn || state_r == ST_INIT) begin
			for (int k = 0; k < NUM_OCTETS; k++) begin
				octet_r[k] <= OCTET_RESET;
			end
		end else if (octetWr) begin
			octet_r[octetSlot(reqIdx)] <= apbReq.pwdata[OCTET_W-1:0];
		end
	end

	// Lowest index carries the leading octet
	assign cfg.echoReplyBlock = echoBlock_r;
	assign cfg.pppoeEnable    = pppoe_r;
	assign cfg.gatewayAddress = {octet_r[0], octet_r[1], octet_r[2], octet_r[3]};
	assign cfg.subnetMask     = {octet_r[4], octet_r[5], octet_r[6], octet_r[7]};
	assign cfg.localHwAddress = {octet_r[8], octet_r[9], octet_r[10], octet_r[11],
		octet_r[12], octet_r[13]};
	assign cfg.localIpAddress = {octet_r[14], octet_r[15], octet_r[16], octet_r[17]};

	// ****************************************************************
	// Bus answer
	// ****************************************************************
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			apbRsp <= '0;
		end else if (accessPend) begin
			apbRsp.pready  <= 1'b1;
			apbRsp.pslverr <= !reqMapped;
			if (!reqMapped) begin
				apbRsp.prdata <= '0;
			end else if (reqIdx == IDX_MODE) begin
				apbRsp.prdata <= {{(DATA_W-OCTET_W){1'b0}}, modeRead};
			end else begin
				apbRsp.prdata <= {{(DATA_W-OCTET_W){1'b0}}, octet_r[octetSlot(reqIdx)]};
			end
		end else begin
			apbRsp <= '0;
		end
	end

	// ****************************************************************
	// Assertions
	// ****************************************************************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	logic [SLOT_W-1:0] slotHold_r;
	logic [OCTET_W-1:0] dataHold_r;
	logic              octetWrHold_r;
	always_ff @(posedge sys_clk) begin
		slotHold_r    <= octetSlot(reqIdx);
		dataHold_r    <= apbReq.pwdata[OCTET_W-1:0];
		octetWrHold_r <= rstn && octetWr;
	end

	AST_SOFT_RESET_CLEARS: assert property (
		softReq |=> state_r == ST_INIT && initBusy && !cfg.pppoeEnable && !cfg.echoReplyBlock
			##1 cfg.gatewayAddress == '0 && cfg.localHwAddress == '0)
		else $error("soft reset did not clear registers");

	AST_SOFT_RESET_SELF_CLEARS: assert property (
		state_r == ST_INIT && initCount_r == '0 |=> state_r == ST_RUN && !initBusy
			&& modeRead[MODE_RST_BIT] == 1'b0)
		else $error("reset bit did not clear itself");

	AST_ECHO_BLOCK_FOLLOWS_WRITE: assert property (
		wrDone && reqIdx == IDX_MODE && !softReq |=>
			cfg.echoReplyBlock == $past(apbReq.pwdata[MODE_ECHO_BIT]))
		else $error("echo block bit not taken");

	AST_PPPOE_FOLLOWS_WRITE: assert property (
		wrDone && reqIdx == IDX_MODE && !softReq |=>
			cfg.pppoeEnable == $past(apbReq.pwdata[MODE_PPPOE_BIT]))
		else $error("PPPoE bit not taken");

	AST_MODE_STABLE: assert property (
		!(wrDone && reqIdx == IDX_MODE) && state_r == ST_RUN |=> $stable(cfg.pppoeEnable)
			&& $stable(cfg.echoReplyBlock))
		else $error("mode bits changed without a write");

	AST_RESET_VALUES: assert property (@(posedge sys_clk) disable iff (1'b0)
		!rstn |=> !initBusy && apbRsp == '0 && !cfg.echoReplyBlock && !cfg.pppoeEnable
			&& cfg.gatewayAddress == '0
			&& cfg.subnetMask == '0 && cfg.localHwAddress == '0 && cfg.localIpAddress == '0)
		else $error("registers not zero after reset");

	AST_GATEWAY_WRITE: assert property (
		octetWrHold_r && slotHold_r < 5'd4 |->
			cfg.gatewayAddress[(3 - slotHold_r) * 8 +: 8] == dataHold_r)
		else $error("gateway octet not written");

	AST_MASK_WRITE: assert property (
		octetWrHold_r && slotHold_r >= 5'd4 && slotHold_r < 5'd8 |->
			cfg.subnetMask[(7 - slotHold_r) * 8 +: 8] == dataHold_r)
		else $error("mask octet not written");

	AST_HW_WRITE: assert property (
		octetWrHold_r && slotHold_r >= 5'd8 && slotHold_r < 5'd14 |->
			cfg.localHwAddress[(13 - slotHold_r) * 8 +: 8] == dataHold_r)
		else $error("hardware address octet not written");

	AST_IP_WRITE: assert property (
		octetWrHold_r && slotHold_r >= 5'd14 |->
			cfg.localIpAddress[(17 - slotHold_r) * 8 +: 8] == dataHold_r)
		else $error("local address octet not written");

	AST_LEADING_OCTET_READ: assert property (
		accessPend && reqIdx == IDX_GW && reqMapped |=>
			apbRsp.prdata[7:0] == cfg.gatewayAddress[31:24] && apbRsp.pready)
		else $error("leading octet not at lowest index");

	AST_MODE_RESERVED_ZERO: assert property (
		accessPend && reqIdx == IDX_MODE && reqMapped |=>
			apbRsp.prdata[31:8] == '0 && apbRsp.prdata[6:5] == 2'b00
			&& apbRsp.prdata[2:0] == 3'b000)
		else $error("reserved mode bits not zero");

	AST_BUSY_MATCHES_INIT: assert property (
		initBusy == (state_r == ST_INIT))
		else $error("busy flag out of step with reinitialisation");

	AST_NO_ANSWER_WHILE_INIT: assert property (
		state_r == ST_INIT |=> !apbRsp.pready)
		else $error("bus answered during reinitialisation");

	AST_OCTETS_STABLE: assert property (
		!octetWr && state_r == ST_RUN |=> $stable(cfg.gatewayAddress) && $stable(cfg.subnetMask)
			&& $stable(cfg.localHwAddress) && $stable(cfg.localIpAddress))
		else $error("address octets changed without a write");

	AST_MODE_READBACK: assert property (
		accessPend && reqIdx == IDX_MODE && reqMapped |=> !apbRsp.prdata[MODE_RST_BIT]
			&& apbRsp.prdata[MODE_ECHO_BIT] == cfg.echoReplyBlock
			&& apbRsp.prdata[MODE_PPPOE_BIT] == cfg.pppoeEnable)
		else $error("mode readback differs from the mode outputs");

	AST_LEADING_MASK_READ: assert property (
		accessPend && reqIdx == IDX_MASK && reqMapped |=>
			apbRsp.prdata[7:0] == cfg.subnetMask[31:24])
		else $error("leading mask octet not at lowest index");

	AST_LEADING_HW_READ: assert property (
		accessPend && reqIdx == IDX_HW && reqMapped |=>
			apbRsp.prdata[7:0] == cfg.localHwAddress[47:40])
		else $error("leading hardware octet not at lowest index");

	AST_LEADING_IP_READ: assert property (
		accessPend && reqIdx == IDX_IP && reqMapped |=>
			apbRsp.prdata[7:0] == cfg.localIpAddress[31:24])
		else $error("leading local address octet not at lowest index");

	COV_SOFT_RESET: cover property (softReq ##1 initBusy [*2] ##[1:300] !initBusy);
	COV_ECHO_BLOCK: cover property (!cfg.echoReplyBlock ##1 cfg.echoReplyBlock);
	COV_UNMAPPED: cover property (apbRsp.pready && apbRsp.pslverr);
	COV_HW_WRITE: cover property (octetWrHold_r && slotHold_r == 5'd13);
	COV_MODE_READ: cover property (accessPend && reqIdx == IDX_MODE ##1 apbRsp.pready);

endmodule

`default_nettype wire

// >>> sim/cfg_sw_model.sv
`timescale 1ns/100ps
`default_nettype none

module cfg_sw_model (
	// Clock
	input  wire logic                  sys_clk,
	// Register bus
	output var  net_cfg_pkg::apb_req_s apbReq,
	input  wire net_cfg_pkg::apb_rsp_s apbRsp
);
	import net_cfg_pkg::*;

	initial begin
		apbReq = '0;
	end

	// ****************************************
	// One APB transfer, held until pready
	// ****************************************
	task automatic xfer(input logic wr, input logic [23:0] idx, input logic [7:0] wd,
		output logic [7:0] rd, output logic err);
		@(posedge sys_clk);
		apbReq.paddr   <= {6'h00, idx, 2'b00};
		apbReq.pwrite  <= wr;
		apbReq.pwdata  <= {24'h00_0000, wd};
		apbReq.psel    <= 1'b1;
		apbReq.penable <= 1'b0;
		@(posedge sys_clk);
		apbReq.penable <= 1'b1;
		@(posedge sys_clk);
		while (apbRsp.pready !== 1'b1) @(posedge sys_clk);
		rd  = apbRsp.prdata[7:0];
		err = apbRsp.pslverr;
		apbReq.psel    <= 1'b0;
		apbReq.penable <= 1'b0;
		apbReq.pwdata  <= ~apbReq.pwdata;
	endtask
endmodule

`default_nettype wire

// >>> sim/net_common_config_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module net_common_config_regs_tb_top;
	import net_cfg_pkg::*;

	localparam logic [143:0] OCTETS = 144'hC0A8_0001_FFFF_FF00_0008_DC01_0203_C0A8_0002;

	logic     sys_clk;
	logic     rstn;
	apb_req_s apbReq;
	apb_rsp_s apbRsp;
	net_cfg_s cfg;
	logic     initBusy;
	int       errorCnt;
	int       comparisons;

	net_common_config_regs #(.INIT_LEN(4)) i_net_common_config_regs (
		.sys_clk (sys_clk),
		.rstn    (rstn),
		.apbReq  (apbReq),
		.apbRsp  (apbRsp),
		.cfg     (cfg),
		.initBusy(initBusy)
	);

	cfg_sw_model i_cfg_sw_model (
		.sys_clk(sys_clk),
		.apbReq (apbReq),
		.apbRsp (apbRsp)
	);

	// ****************************************
	// Helpers
	// ****************************************
	task automatic check(input logic [159:0] got, input logic [159:0] exp, input string what);
		comparisons++;
		if (got !== exp) begin
			errorCnt++;
			$display("BAD %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic rd(input logic [23:0] idx, input logic [7:0] exp, input logic eExp);
		logic [7:0] d;
		logic       e;
		i_cfg_sw_model.xfer(1'b0, idx, 8'h00, d, e);
		check(160'({e, d}), 160'({eExp, exp}), "read");
	endtask

	task automatic wr(input logic [23:0] idx, input logic [7:0] v);
		logic [7:0] d;
		logic       e;
		i_cfg_sw_model.xfer(1'b1, idx, v, d, e);
	endtask

	task automatic close_out;
		$display("Errors %0d comparisons %0d", errorCnt, comparisons);
		if (errorCnt == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	// ****************************************
	// Clock, reset and watchdog
	// ****************************************
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	initial begin
		repeat (3000) @(posedge sys_clk);
		errorCnt++;
		close_out;
	end

	// ****************************************
	// Tests
	// ****************************************
	initial begin
		errorCnt    = 0;
		comparisons = 0;
		rstn        = 1'b0;
		repeat (10) @(posedge sys_clk);
		rstn <= 1'b1;
		for (int i = 0; i < 19; i++) rd(IDX_MODE + 24'(i), 8'h00, 1'b0);
		check(160'(cfg), 160'(0), "cfg after reset");
		wr(IDX_MODE, 8'h7F);
		rd(IDX_MODE, 8'h18, 1'b0);
		check(160'({cfg.echoReplyBlock, cfg.pppoeEnable}), 160'(2'b11), "mode flags");
		wr(IDX_MODE, 8'h08);
		@(posedge sys_clk);
		check(160'({cfg.echoReplyBlock, cfg.pppoeEnable}), 160'(2'b01), "mode flags");
		for (int i = 0; i < 18; i++) wr(IDX_GW + 24'(i), OCTETS[143-8*i -: 8]);
		for (int i = 0; i < 18; i++) rd(IDX_GW + 24'(i), OCTETS[143-8*i -: 8], 1'b0);
		check(160'({cfg.gatewayAddress, cfg.subnetMask, cfg.localHwAddress, cfg.localIpAddress}),
			160'(OCTETS), "octet order");
		wr(IDX_LAST + 24'h00_0001, 8'h55);
		rd(IDX_LAST + 24'h00_0001, 8'h00, 1'b1);
		wr(IDX_MODE, 8'h98);
		@(posedge sys_clk);
		check(160'({initBusy, cfg.echoReplyBlock, cfg.pppoeEnable}), 160'(3'b100),
			"reinit start");
		rd(IDX_MODE, 8'h00, 1'b0);
		check(160'(initBusy), 160'(0), "reinit end");
		rd(IDX_GW, 8'h00, 1'b0);
		check(160'(cfg), 160'(0), "cfg after soft reset");
		wr(IDX_IP, 8'hC0);
		wr(IDX_MODE, 8'h18);
		rstn <= 1'b0;
		repeat (2) @(posedge sys_clk);
		rstn <= 1'b1;
		check(160'(cfg), 160'(0), "cfg after second reset");
		check(160'({initBusy, apbRsp}), 160'(0), "bus after second reset");
		rd(IDX_MODE, 8'h00, 1'b0);
		rd(IDX_IP, 8'h00, 1'b0);
		close_out;
	end
endmodule

`default_nettype wire
